// >>> src/aimg_ctrl.sv
// analog input mode selection, clamp reference, blanking window and gain control
//
// Function
// - VSB codes 00 0000, 00 0001, 00 1110, 00 1111 route group 1 inputs 1 to 4 with reference flag 1, output select 0 and fixed gain.
// - VSB codes 00 0010 to 00 0101 route group 2 inputs 1 to 4 with reference flag 1, output select 1 and fixed gain.
// - VSB codes 01 0000, 01 0001, 01 1110, 01 1111 route group 3 inputs 1 to 4 with reference flag 1, output select 2 and fixed gain.
// - VSB codes 01 0010 to 01 0101 route group 4 inputs 1 to 4 with reference flag 1, output select 3 and fixed gain.
// - while unlocked, clamp-reference bit 0 gives normal clamping and 1 gives reference selection.
// - blanking-length bit 0 suspends gain control only during equalization and serration pulses.
// - blanking-length bit 1 suspends gain control from pre-equalization start to line 22 (60 Hz) or 24 (50 Hz).
// - colour-peak disable 0 attenuates the signal when the input exceeds its maximum; 1 turns this off.
// - integrator freeze 1 holds the gain integrator at its current value.
// - manual gain select 1 takes each channel gain from its static gain fields.
// - control bit 1 is the sign bit of channel 2 static gain and bit 0 that of channel 1.
// - static gain is 9 bits, 0 for -3 dB, 144 for 0 dB and 511 for +6 dB.
`default_nettype none
`include "aimg_regs.svh"
module aimg_ctrl
  import aimg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_ack,
  input wire logic [7:0] i_ch1_gain_low,
  input wire logic [7:0] i_ch2_gain_low,
  input wire logic i_locked,
  input wire logic i_field_60hz,
  input wire logic [9:0] i_line_num,
  input wire logic i_eq_serr,
  input wire logic i_pre_eq_start,
  input wire logic i_over_max,
  input wire logic i_agc_tick,
  input wire logic [1:0] i_level_low,
  input wire logic [1:0] i_level_high,
  output logic o_vsb_mode,
  output logic [1:0] o_input_group,
  output logic [1:0] o_input_idx,
  output logic o_reference_flag,
  output logic [1:0] o_output_channel_sel,
  output logic o_fast_switch_enable,
  output logic o_fast_switch_invert,
  output logic o_clamp_ref_active,
  output logic o_agc_blank,
  output logic o_color_peak_atten,
  output logic o_agc_hold,
  output logic o_gain_manual,
  output logic [8:0] o_ch1_gain,
  output logic [8:0] o_ch2_gain
);

  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  aimg_ctrl_t ctrl_r;
  aimg_ctrl_t ctrl_nxt;
  aimg_route_t route;
  aimg_vb_state_t vb_state_r;
  aimg_vb_state_t vb_state_nxt;
  logic [9:0] line_end;
  logic blank_nxt;
  logic manual;
  logic agc_run;
  logic [8:0] static_gain [2];
  logic [8:0] gain_acc_r [2];

  // register writes
  always_comb begin
    mode_nxt = mode_r;
    ctrl_nxt = ctrl_r;
    if (i_reg_wr && (i_reg_addr == `AIMG_ADDR_MODE)) begin
      mode_nxt = i_reg_wdata;
    end
    if (i_reg_wr && (i_reg_addr == `AIMG_ADDR_CTRL)) begin
      ctrl_nxt = aimg_ctrl_t'(i_reg_wdata[6:0]);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= `AIMG_MODE_RST;
      ctrl_r <= aimg_ctrl_t'(7'(`AIMG_CTRL_RST));
    end else begin
      mode_r <= mode_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // register reads; unmapped subaddresses answer zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_wr | i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `AIMG_ADDR_MODE: begin
            o_reg_rdata <= mode_r;
          end
          `AIMG_ADDR_CTRL: begin
            o_reg_rdata <= {1'b0, ctrl_r} & `AIMG_CTRL_MASK;
          end
          default: begin
            o_reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

  aimg_mode_decode u_mode_decode (
    .i_mode(mode_r[5:0]),
    .o_route(route)
  );

  // routing outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vsb_mode <= 1'b0;
      o_input_group <= 2'h0;
      o_input_idx <= 2'h0;
      o_reference_flag <= 1'b0;
      o_output_channel_sel <= 2'h0;
      o_fast_switch_enable <= 1'b0;
      o_fast_switch_invert <= 1'b0;
    end else begin
      o_vsb_mode <= route.vsb;
      o_input_group <= route.group;
      o_input_idx <= route.input_idx;
      o_reference_flag <= route.reference_flag;
      o_output_channel_sel <= route.output_channel_sel;
      o_fast_switch_enable <= mode_r[`AIMG_MODE_FSW_EN];
      o_fast_switch_invert <= mode_r[`AIMG_MODE_FSW_INV];
    end
  end

  // clamp reference choice in the unlocked state
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clamp_ref_active <= 1'b0;
    end else begin
      o_clamp_ref_active <= !i_locked && ctrl_r.unlocked_clamp_ref_sel;
    end
  end

  // long vertical blanking window
  assign line_end = i_field_60hz ? `AIMG_LINE_END_60 : `AIMG_LINE_END_50;

  always_comb begin
    vb_state_nxt = vb_state_r;
    case (vb_state_r)
      AIMG_VB_IDLE: begin
        if (i_pre_eq_start) begin
          vb_state_nxt = AIMG_VB_LONG;
        end
      end
      AIMG_VB_LONG: begin
        if (i_line_num == line_end) begin
          vb_state_nxt = AIMG_VB_IDLE;
        end
      end
      default: begin
        vb_state_nxt = AIMG_VB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vb_state_r <= AIMG_VB_IDLE;
    end else begin
      vb_state_r <= vb_state_nxt;
    end
  end

  always_comb begin
    if (ctrl_r.blanking_length_sel) begin
      blank_nxt = (vb_state_nxt == AIMG_VB_LONG);
    end else begin
      blank_nxt = i_eq_serr;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_agc_blank <= 1'b0;
    end else begin
      o_agc_blank <= blank_nxt;
    end
  end

  // colour peak limiting
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_color_peak_atten <= 1'b0;
    end else begin
      o_color_peak_atten <= i_over_max && !ctrl_r.color_peak_disable;
    end
  end

  // gain selection and integrators
  assign manual = ctrl_r.manual_gain_sel | (route.vsb & route.fixed_gain);
  assign agc_run = i_agc_tick && !ctrl_r.gain_integrator_freeze && !o_agc_blank && !manual;
  assign static_gain[0] = {ctrl_r.ch1_gain_sign, i_ch1_gain_low};
  assign static_gain[1] = {ctrl_r.ch2_gain_sign, i_ch2_gain_low};

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_agc_hold <= 1'b0;
      o_gain_manual <= 1'b0;
    end else begin
      o_agc_hold <= ctrl_r.gain_integrator_freeze;
      o_gain_manual <= manual;
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        gain_acc_r[ch] <= `AIMG_GAIN_UNITY;
      end else if (agc_run) begin
        if (i_level_low[ch] && (gain_acc_r[ch] != `AIMG_GAIN_MAX)) begin
          gain_acc_r[ch] <= gain_acc_r[ch] + 9'h001;
        end else if (i_level_high[ch] && (gain_acc_r[ch] != `AIMG_GAIN_MIN)) begin
          gain_acc_r[ch] <= gain_acc_r[ch] - 9'h001;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ch1_gain <= `AIMG_GAIN_UNITY;
      o_ch2_gain <= `AIMG_GAIN_UNITY;
    end else begin
      o_ch1_gain <= manual ? static_gain[0] : gain_acc_r[0];
      o_ch2_gain <= manual ? static_gain[1] : gain_acc_r[1];
    end
  end

endmodule : aimg_ctrl
`default_nettype wire

// >>> src/aimg_regs.svh
// register offsets, field positions, reset values and gain constants for the analog input control
`ifndef AIMG_REGS_SVH
`define AIMG_REGS_SVH

`define AIMG_ADDR_MODE 8'h02
`define AIMG_ADDR_CTRL 8'h03

`define AIMG_MODE_RST 8'h00
`define AIMG_CTRL_RST 8'h00
`define AIMG_CTRL_MASK 8'h7F

`define AIMG_MODE_FSW_EN 7
`define AIMG_MODE_FSW_INV 6

`define AIMG_CTRL_CLAMP_REF 6
`define AIMG_CTRL_BLANK_LEN 5
`define AIMG_CTRL_PEAK_OFF 4
`define AIMG_CTRL_FREEZE 3
`define AIMG_CTRL_MANUAL 2
`define AIMG_CTRL_CH2_SIGN 1
`define AIMG_CTRL_CH1_SIGN 0

`define AIMG_LINE_END_60 10'h016
`define AIMG_LINE_END_50 10'h018

`define AIMG_GAIN_MIN 9'h000
`define AIMG_GAIN_UNITY 9'h090
`define AIMG_GAIN_MAX 9'h1FF

`endif

// >>> src/aimg_pkg.sv
// types shared by the analog input mode and gain control
`default_nettype none
package aimg_pkg;

  typedef struct packed {
    logic vsb;
    logic [1:0] group;
    logic [1:0] input_idx;
    logic reference_flag;
    logic [1:0] output_channel_sel;
    logic fixed_gain;
  } aimg_route_t;

  typedef struct packed {
    logic unlocked_clamp_ref_sel;
    logic blanking_length_sel;
    logic color_peak_disable;
    logic gain_integrator_freeze;
    logic manual_gain_sel;
    logic ch2_gain_sign;
    logic ch1_gain_sign;
  } aimg_ctrl_t;

  typedef enum logic [0:0] {
    AIMG_VB_IDLE = 1'b0,
    AIMG_VB_LONG = 1'b1
  } aimg_vb_state_t;

endpackage : aimg_pkg
`default_nettype wire

// >>> src/aimg_mode_decode.sv
// combinational decode of the 6-bit mode field into input routing and forced settings
`default_nettype none
module aimg_mode_decode
  import aimg_pkg::*;
(
  input wire logic [5:0] i_mode,
  output aimg_route_t o_route
);

  always_comb begin
    o_route = '0;
    if (i_mode[5] == 1'b0) begin
      case (i_mode[3:0])
        4'h0, 4'h1, 4'hE, 4'hF: begin
          o_route.vsb = 1'b1;
          // upper half picks group 3, lower half group 1
          o_route.group = {i_mode[4], 1'b0};
          o_route.input_idx = {i_mode[3], i_mode[0]};
          o_route.reference_flag = 1'b1;
          o_route.output_channel_sel = {i_mode[4], 1'b0};
          o_route.fixed_gain = 1'b1;
        end
        4'h2, 4'h3, 4'h4, 4'h5: begin
          o_route.vsb = 1'b1;
          o_route.group = {i_mode[4], 1'b1};
          o_route.input_idx = 2'(i_mode[3:0] - 4'h2);
          o_route.reference_flag = 1'b1;
          o_route.output_channel_sel = {i_mode[4], 1'b1};
          o_route.fixed_gain = 1'b1;
        end
        default: begin
          o_route = '0;
        end
      endcase
    end
  end

endmodule : aimg_mode_decode
`default_nettype wire

// >>> testbench/aimg_front_model.sv
// line timing and level detectors of the analog front end
`default_nettype none
module aimg_front_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [8:0] i_target,
  input wire logic [8:0] i_ch1_gain,
  input wire logic [8:0] i_ch2_gain,
  output logic [9:0] o_line_num,
  output logic o_eq_serr,
  output logic o_pre_eq_start,
  output logic o_agc_tick,
  output logic [1:0] o_level_low,
  output logic [1:0] o_level_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // one line per clock, 32 lines per field
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line_num <= 10'h000;
    end else begin
      o_line_num <= (o_line_num == 10'h01F) ? 10'h000 : o_line_num + 10'h001;
    end
  end
  assign o_pre_eq_start = o_line_num == 10'h003;
  assign o_eq_serr = o_line_num > 10'h003 && o_line_num < 10'h00A;
  assign o_agc_tick = o_line_num[1:0] == 2'h0;
  assign o_level_low = {i_ch2_gain < i_target, i_ch1_gain < i_target};
  assign o_level_high = {i_ch2_gain > i_target, i_ch1_gain > i_target};
endmodule : aimg_front_model
`default_nettype wire

// >>> testbench/aimg_ctrl_chk.sv
// port assertions for the analog input control
`default_nettype none
module aimg_ctrl_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] i_ch1_gain_low,
  input wire logic i_locked,
  input wire logic i_field_60hz,
  input wire logic [9:0] i_line_num,
  input wire logic i_eq_serr,
  input wire logic i_over_max,
  input wire logic o_reg_ack,
  input wire logic o_vsb_mode,
  input wire logic [1:0] o_input_group,
  input wire logic o_reference_flag,
  input wire logic [1:0] o_output_channel_sel,
  input wire logic o_clamp_ref_active,
  input wire logic o_agc_blank,
  input wire logic o_color_peak_atten,
  input wire logic o_agc_hold,
  input wire logic o_gain_manual,
  input wire logic [8:0] o_ch1_gain,
  input wire logic [8:0] o_ch2_gain
);
  timeunit 1ns;
  timeprecision 1ps;
  // mirror of control bits 6, 5, 4 and 0
  logic [3:0] ctl_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_r <= 4'h0;
    end else if (i_reg_wr && i_reg_addr == 8'h03) begin
      ctl_r <= {i_reg_wdata[6:4], i_reg_wdata[0]};
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  chk_ack_after_req: assert property (o_reg_ack == $past(i_reg_wr || i_reg_rd))
    else $error("ack not one cycle after request");
  chk_vsb_ref_flag: assert property (o_vsb_mode |-> o_reference_flag)
    else $error("reference flag low in vsb mode");
  chk_group_outsel: assert property (o_vsb_mode |-> o_output_channel_sel == o_input_group)
    else $error("output select differs from group");
  chk_vsb_fixed_gain: assert property (o_vsb_mode |-> o_gain_manual)
    else $error("vsb mode without fixed gain");
  chk_clamp_unlock: assert property (o_clamp_ref_active == (!$past(i_locked) && $past(ctl_r[3])))
    else $error("clamp reference select wrong");
  chk_peak_cause: assert property (o_color_peak_atten == ($past(i_over_max) && !$past(ctl_r[1])))
    else $error("colour peak attenuation wrong");
  chk_short_blank: assert property (!$past(ctl_r[2]) |-> o_agc_blank == $past(i_eq_serr))
    else $error("short blanking wrong");
  chk_long_end: assert property (ctl_r[2] && o_agc_blank
    && i_line_num == (i_field_60hz ? 10'h016 : 10'h018) |-> ##[1:2] !o_agc_blank)
    else $error("long blanking does not end");
  chk_manual_gain: assert property (o_gain_manual
    |-> o_ch1_gain == {$past(ctl_r[0]), $past(i_ch1_gain_low)})
    else $error("manual gain not taken from static fields");
  chk_hold_gain: assert property ((o_agc_hold && !o_gain_manual) [*3]
    |-> $stable(o_ch1_gain) && $stable(o_ch2_gain))
    else $error("gain moved while frozen");
  cov_long: cover property (ctl_r[2] && o_agc_blank ##1 !o_agc_blank);
  cov_clamp: cover property (o_clamp_ref_active);
  cov_atten: cover property (o_color_peak_atten);
endmodule : aimg_ctrl_chk
bind aimg_ctrl aimg_ctrl_chk u_chk (.i_clk_sys, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr,
  .i_reg_wdata, .i_ch1_gain_low, .i_locked, .i_field_60hz, .i_line_num, .i_eq_serr, .i_over_max,
  .o_reg_ack, .o_vsb_mode, .o_input_group, .o_reference_flag, .o_output_channel_sel,
  .o_clamp_ref_active, .o_agc_blank, .o_color_peak_atten, .o_agc_hold, .o_gain_manual,
  .o_ch1_gain, .o_ch2_gain);
`default_nettype wire

// >>> testbench/aimg_ctrl_bench.sv
// self-checking bench for the analog input control
`default_nettype none
module aimg_ctrl_bench;
  import aimg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys, i_rst_n, i_reg_wr, i_reg_rd, i_locked, i_field_60hz, i_over_max;
  logic i_eq_serr, i_pre_eq_start, i_agc_tick, o_reg_ack, o_vsb_mode, o_reference_flag;
  logic o_fast_switch_enable, o_fast_switch_invert, o_clamp_ref_active, o_agc_blank;
  logic o_color_peak_atten, o_agc_hold, o_gain_manual;
  logic [1:0] i_level_low, i_level_high, o_input_group, o_input_idx, o_output_channel_sel;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_ch1_gain_low, i_ch2_gain_low;
  logic [8:0] o_ch1_gain, o_ch2_gain, target;
  logic [9:0] i_line_num;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [5:0] codes [16] = '{6'h00, 6'h01, 6'h0E, 6'h0F, 6'h02, 6'h03, 6'h04, 6'h05,
    6'h10, 6'h11, 6'h1E, 6'h1F, 6'h12, 6'h13, 6'h14, 6'h15};
  aimg_ctrl i_dut (.i_clk_sys, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_ack, .i_ch1_gain_low, .i_ch2_gain_low, .i_locked, .i_field_60hz,
    .i_line_num, .i_eq_serr, .i_pre_eq_start, .i_over_max, .i_agc_tick, .i_level_low,
    .i_level_high, .o_vsb_mode, .o_input_group, .o_input_idx, .o_reference_flag,
    .o_output_channel_sel, .o_fast_switch_enable, .o_fast_switch_invert, .o_clamp_ref_active,
    .o_agc_blank, .o_color_peak_atten, .o_agc_hold, .o_gain_manual, .o_ch1_gain, .o_ch2_gain);
  aimg_front_model i_front (.i_clk_sys, .i_rst_n, .i_target(target), .i_ch1_gain(o_ch1_gain),
    .i_ch2_gain(o_ch2_gain), .o_line_num(i_line_num), .o_eq_serr(i_eq_serr),
    .o_pre_eq_start(i_pre_eq_start), .o_agc_tick(i_agc_tick), .o_level_low(i_level_low),
    .o_level_high(i_level_high));
  always #10 i_clk_sys = ~i_clk_sys;
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(posedge i_clk_sys) #1;
    i_reg_wr = 1'b0;
    @(posedge i_clk_sys) #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(posedge i_clk_sys) #1;
    i_reg_rd = 1'b0;
    chk("rdata", o_reg_rdata, exp);
    @(posedge i_clk_sys) #1;
  endtask : rd
  task automatic to_line(input logic [9:0] n);
    for (int w = 0; w < 40 && i_line_num !== n; w++) @(posedge i_clk_sys) #1;
  endtask : to_line
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {i_clk_sys, i_rst_n, i_reg_wr, i_reg_rd, i_locked, i_field_60hz, i_over_max} = 7'h00;
    {i_reg_addr, i_reg_wdata} = 16'h0000;
    i_ch1_gain_low = 8'h90;
    i_ch2_gain_low = 8'hFF;
    target = 9'h096;
    repeat (12) @(posedge i_clk_sys);
    chk("gain_rst", o_ch1_gain, 9'h090);
    #1 i_rst_n = 1'b1;
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    for (int k = 0; k < 16; k++) begin
      wr(8'h02, {2'h0, codes[k]});
      chk("route", {o_vsb_mode, o_input_group, o_input_idx, o_reference_flag,
        o_output_channel_sel, o_gain_manual}, {1'h1, 2'(k / 4), 2'(k % 4), 1'h1, 2'(k / 4),
        1'h1});
    end
    wr(8'h02, 8'hC6);
    chk("fsw", {o_vsb_mode, o_fast_switch_enable, o_fast_switch_invert}, 3'h3);
    rd(8'h02, 8'hC6);
    wr(8'h09, 8'h80);
    rd(8'h09, 8'h00);
    wr(8'h05, 8'hAA);
    rd(8'h05, 8'h00);
    i_over_max = 1'b1;
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h7F);
    chk("gains", {o_ch1_gain, o_ch2_gain}, 18'h321FF);
    chk("clamp", {o_clamp_ref_active, o_color_peak_atten, o_agc_hold}, 3'h5);
    i_locked = 1'b1;
    wr(8'h03, 8'h44);
    chk("gains", {o_ch1_gain, o_ch2_gain}, 18'h120FF);
    chk("clamp", {o_clamp_ref_active, o_color_peak_atten}, 2'h1);
    i_locked = 1'b0;
    wr(8'h03, 8'h00);
    to_line(10'h005);
    chk("blank_short", o_agc_blank, 1'h1);
    to_line(10'h00F);
    chk("blank_short", o_agc_blank, 1'h0);
    repeat (400) @(posedge i_clk_sys) #1;
    chk("agc", {o_ch1_gain, o_ch2_gain}, 18'h12C96);
    wr(8'h03, 8'h08);
    target = 9'h0A0;
    repeat (200) @(posedge i_clk_sys) #1;
    chk("freeze", {o_ch1_gain, o_ch2_gain}, 18'h12C96);
    wr(8'h03, 8'h20);
    for (int f = 0; f < 2; f++) begin
      i_field_60hz = f[0];
      to_line(10'h00F);
      chk("blank_long", o_agc_blank, 1'h1);
      to_line(10'h017);
      chk("blank_end", o_agc_blank, f == 0);
    end
    wr(8'h03, 8'h00);
    repeat (300) @(posedge i_clk_sys) #1;
    chk("agc", {o_ch1_gain, o_ch2_gain}, 18'h140A0);
    complete_run();
  end
endmodule : aimg_ctrl_bench
`default_nettype wire
